//--- logic/meas_seq.v
`timescale 1ns/1ps
`include "meas_seq_defs.vh"
module meas_seq (
  input  wire                 I_MCLK,             // 40 MHz clock
  input  wire                 I_SRST,             // Synchronous reset, active high
  input  wire                 i_start_single,     // Single start command pulse
  input  wire                 i_start_cont,       // Continuous start command pulse
  input  wire                 i_abort,            // Return to idle pulse
  input  wire                 i_force_trig,       // Force trigger command pulse
  input  wire                 i_bus_trig,         // Common trigger command pulse
  input  wire [2:0]           i_trig_source,      // Trigger source select
  input  wire                 i_trig_slope_neg,   // 1: trigger on falling power
  input  wire                 i_pwr_above_level,  // Power beyond level, async
  input  wire                 i_pwr_above_hyst,   // Power beyond level minus hysteresis, async
  input  wire                 i_ext1_trig,        // External 1 differential trigger, async
  input  wire                 i_ext2_trig,        // External 2 coax trigger, async
  input  wire [`TIME_W-1:0]   i_delay_cycles,     // Trigger delay in clocks
  input  wire [`TIME_W-1:0]   i_dropout_cycles,   // Dropout time in clocks
  input  wire [`TIME_W-1:0]   i_holdoff_cycles,   // Hold-off time in clocks
  input  wire [`TIME_W-1:0]   i_aperture_cycles,  // Aperture in clocks, at least 1
  input  wire [`CNT_W-1:0]    i_avg_count,        // Average count, at least 1
  input  wire [`CNT_W-1:0]    i_trig_count,       // Trigger count, 0 for unlimited
  input  wire                 i_termination_control_select, // 0 repeat, 1 moving
  input  wire                 i_trace_mode,       // Trace mode selected
  input  wire [31:0]          i_sample,           // Partial measurement value
  output wire [1:0]           o_state,            // Sequencer state
  output reg                  o_chop_inverted,    // Inverted chopper phase active
  output reg                  o_trig_sync,        // Trigger synchronisation output
  output reg                  o_result_valid,     // Result pulse
  output reg  [31:0]          o_result,           // Averaged result
  output reg                  o_result_settled,   // Result averages full count
  output reg                  o_trace_point       // Result is one entry of a trace array
);
  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  reg [3:0] sync1_reg;
  reg [3:0] sync2_reg;
  always @(posedge I_MCLK) begin
    if (I_SRST) begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
    end else begin
      sync1_reg <= {i_ext2_trig, i_ext1_trig, i_pwr_above_hyst, i_pwr_above_level};
      sync2_reg <= sync1_reg;
    end
  end

  // ----------------------------------------------------------------
  // Threshold qualification with dropout
  // ----------------------------------------------------------------
  // Beyond: power past the trigger level; back: returned past the hysteresis band.
  wire beyond = i_trig_slope_neg ? ~sync2_reg[1] : sync2_reg[0];
  wire back   = i_trig_slope_neg ? sync2_reg[0] : ~sync2_reg[1];
  reg             armed_reg;
  reg             beyond_reg;
  reg [`TIME_W-1:0] drop_reg;
  reg             ext1_d_reg;
  reg             ext2_d_reg;
  wire            int_event;
  // The dropout timer runs while power stays short of the trigger level before the crossing.
  always @(posedge I_MCLK) begin
    if (I_SRST) begin
      armed_reg  <= 1'b0;
      beyond_reg <= 1'b0;
      drop_reg   <= {`TIME_W{1'b0}};
      ext1_d_reg <= 1'b0;
      ext2_d_reg <= 1'b0;
    end else begin
      ext1_d_reg <= sync2_reg[2];
      ext2_d_reg <= sync2_reg[3];
      beyond_reg <= beyond;
      if (beyond != beyond_reg) begin
        drop_reg <= {`TIME_W{1'b0}};
      end else if (drop_reg != {`TIME_W{1'b1}}) begin
        drop_reg <= drop_reg + 1'b1;
      end
      if (back && drop_reg >= i_dropout_cycles) begin
        armed_reg <= 1'b1;
      end else if (beyond && !beyond_reg) begin
        armed_reg <= 1'b0;
      end
    end
  end
  assign int_event = beyond && !beyond_reg && armed_reg;

  // ----------------------------------------------------------------
  // Source selection and hold-off
  // ----------------------------------------------------------------
  reg [`TIME_W-1:0] holdoff_reg;
  reg               src_event;
  always @* begin
    case (i_trig_source)
      `SRC_INTERNAL:  src_event = int_event;
      `SRC_EXT1:      src_event = sync2_reg[2] & ~ext1_d_reg;
      `SRC_EXT2:      src_event = sync2_reg[3] & ~ext2_d_reg;
      `SRC_BUS:       src_event = i_bus_trig;
      `SRC_IMMEDIATE: src_event = 1'b1;
      default:        src_event = 1'b0;
    endcase
  end
  wire holdoff_busy = (holdoff_reg != {`TIME_W{1'b0}});
  wire trig_ok = ((src_event && !holdoff_busy) || i_force_trig);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  reg [1:0]         state_reg;
  reg               cont_reg;
  reg [`TIME_W-1:0] tmr_reg;
  reg [`CNT_W-1:0]  rep_reg;
  reg [`CNT_W-1:0]  fill_reg;
  reg [`CNT_W-1:0]  trig_cnt_reg;
  reg [47:0]        acc_reg;
  reg [31:0]        hist [0:255];
  reg [7:0]         wr_ptr_reg;
  assign o_state = state_reg;

  wire single_ap  = (i_avg_count == 16'h0001);
  wire moving     = (i_termination_control_select == `TCTL_MOVING) && !single_ap;
  wire phase_done = (tmr_reg + 1'b1 >= i_aperture_cycles);
  wire meas_done  = phase_done && (o_chop_inverted || single_ap);
  wire cycle_done = moving ? 1'b1 : (rep_reg + 1'b1 >= i_avg_count);
  wire trig_limit = (i_trig_count != 16'h0000) && (trig_cnt_reg >= i_trig_count);
  wire [7:0]  old_ptr = wr_ptr_reg - i_avg_count[7:0];
  wire [31:0] old_val = (fill_reg >= i_avg_count) ? hist[old_ptr] : 32'h00000000;
  wire [47:0] acc_mov = acc_reg + {16'h0000, i_sample} - {16'h0000, old_val};
  wire [47:0] acc_rep = acc_reg + {16'h0000, i_sample};
  wire [`CNT_W-1:0] fill_inc = (fill_reg < i_avg_count) ? fill_reg + 1'b1 : fill_reg;
  // Quotients stay 48 bits wide; the result port keeps the low word on purpose.
  wire [47:0] quo_mov = acc_mov / {32'h00000000, fill_inc};
  wire [47:0] quo_rep = acc_rep / {32'h00000000, i_avg_count};

  // Moving history covers counts up to 256 entries; larger counts would wrap it.
  always @(posedge I_MCLK) begin
    if (state_reg == `ST_MEAS && meas_done && moving) begin
      hist[wr_ptr_reg] <= i_sample;
    end
  end

  always @(posedge I_MCLK) begin
    if (I_SRST) begin
      state_reg        <= `ST_IDLE;
      cont_reg         <= 1'b0;
      tmr_reg          <= {`TIME_W{1'b0}};
      holdoff_reg      <= {`TIME_W{1'b0}};
      rep_reg          <= {`CNT_W{1'b0}};
      fill_reg         <= {`CNT_W{1'b0}};
      trig_cnt_reg     <= {`CNT_W{1'b0}};
      acc_reg          <= 48'h000000000000;
      wr_ptr_reg       <= 8'h00;
      o_chop_inverted  <= 1'b0;
      o_trig_sync      <= 1'b0;
      o_result_valid   <= 1'b0;
      o_result         <= 32'h00000000;
      o_result_settled <= 1'b0;
      o_trace_point    <= 1'b0;
    end else begin
      o_result_valid <= 1'b0;
      if (holdoff_busy) begin
        holdoff_reg <= holdoff_reg - 1'b1;
      end
      if (i_abort) begin
        state_reg       <= `ST_IDLE;
        o_trig_sync     <= 1'b0;
        o_chop_inverted <= 1'b0;
        cont_reg        <= 1'b0;
      end else begin
        case (state_reg)
          `ST_IDLE: begin
            if (i_start_single || i_start_cont) begin
              state_reg    <= `ST_WAIT;
              cont_reg     <= i_start_cont;
              rep_reg      <= {`CNT_W{1'b0}};
              fill_reg     <= {`CNT_W{1'b0}};
              trig_cnt_reg <= {`CNT_W{1'b0}};
              acc_reg      <= 48'h000000000000;
              wr_ptr_reg   <= 8'h00;
            end
          end
          `ST_WAIT: begin
            if (trig_ok) begin
              holdoff_reg  <= i_holdoff_cycles;
              trig_cnt_reg <= trig_cnt_reg + 1'b1;
              tmr_reg      <= {`TIME_W{1'b0}};
              if (i_trig_source == `SRC_INTERNAL && !i_force_trig &&
                  i_delay_cycles != {`TIME_W{1'b0}}) begin
                state_reg <= `ST_DELAY;
              end else begin
                state_reg   <= `ST_MEAS;
                o_trig_sync <= 1'b1;
              end
            end
          end
          `ST_DELAY: begin
            tmr_reg <= tmr_reg + 1'b1;
            if (tmr_reg + 1'b1 >= i_delay_cycles) begin
              tmr_reg     <= {`TIME_W{1'b0}};
              state_reg   <= `ST_MEAS;
              o_trig_sync <= 1'b1;
            end
          end
          `ST_MEAS: begin
            tmr_reg <= tmr_reg + 1'b1;
            if (phase_done && !meas_done) begin
              tmr_reg         <= {`TIME_W{1'b0}};
              o_chop_inverted <= 1'b1;
            end else if (meas_done) begin
              tmr_reg         <= {`TIME_W{1'b0}};
              o_chop_inverted <= 1'b0;
              if (moving) begin
                acc_reg          <= acc_mov;
                fill_reg         <= fill_inc;
                wr_ptr_reg       <= wr_ptr_reg + 1'b1;
                o_result         <= quo_mov[31:0];
                o_result_valid   <= 1'b1;
                o_result_settled <= (fill_inc >= i_avg_count);
              end else if (cycle_done) begin
                acc_reg          <= 48'h000000000000;
                rep_reg          <= {`CNT_W{1'b0}};
                o_result         <= quo_rep[31:0];
                o_result_valid   <= 1'b1;
                o_result_settled <= 1'b1;
              end else begin
                acc_reg <= acc_rep;
                rep_reg <= rep_reg + 1'b1;
              end
              o_trace_point <= i_trace_mode;
              if (cycle_done) begin
                o_trig_sync <= 1'b0;
                if (single_ap || trig_limit || !cont_reg) begin
                  state_reg <= `ST_IDLE;
                  cont_reg  <= 1'b0;
                end else begin
                  state_reg <= `ST_WAIT;
                end
              end
            end
          end
          default: state_reg <= `ST_IDLE;
        endcase
      end
    end
  end
endmodule

//--- logic/meas_seq_defs.vh
`ifndef MEAS_SEQ_DEFS_VH
`define MEAS_SEQ_DEFS_VH
// Overview of operation
// - After reset the sequencer idles and measures nothing until a start command.
// - A single or continuous start moves idle to waiting for trigger.
// - A trigger from the selected source moves waiting into measuring.
// - A finished measurement either starts the next one or returns to idle.
// - Continuous start begins a new cycle automatically after the previous one.
// - Single start runs exactly one measurement cycle; trace mode yields a result array.
// - A power crossing of the trigger level starts measuring after the delay time.
// - Force trigger skips the trigger condition and measures unconditionally.
// - Immediate source measures at once without any trigger condition.
// - Internal uses the power comparator; external 1 and 2 use digital pins.
// - Hold and bus sources trigger only by command; bus also takes common trigger.
// - A crossing counts only once power is back past the hysteresis band and has stayed short of the trigger level for the dropout time.
// - During hold-off after an accepted trigger, further source triggers are ignored; force trigger is still taken.
// - Repeating control repeats average-count measurements, then outputs one result.
// - Moving control outputs a moving average after every partial measurement.
// - Each measurement with average count above 1 is a noninverted then inverted chopper phase of one aperture.
// - Repeating control holds sync high from trigger until the averaged result.
// - Moving control drives sync high during each single measurement.
// - Moving control needs a trigger per measurement; settled once count reached.
// - Accepted triggers are counted; idle once the trigger count is reached.
// - Average count 1 ignores control, runs one aperture, settles, then idles.

// ----------------------------------------------------------------
// Sources, states and widths
// ----------------------------------------------------------------
`define SRC_HOLD       3'h0
`define SRC_IMMEDIATE  3'h1
`define SRC_INTERNAL   3'h2
`define SRC_EXT1       3'h3
`define SRC_EXT2       3'h4
`define SRC_BUS        3'h5
`define ST_IDLE        2'h0
`define ST_WAIT        2'h1
`define ST_DELAY       2'h2
`define ST_MEAS        2'h3
`define TCTL_REPEAT    1'b0
`define TCTL_MOVING    1'b1
`define TIME_W         24
`define CNT_W          16
`endif

//--- testbench/host_cfg.sv
`timescale 1ns/1ps
`include "meas_seq_defs.vh"
// ----------------------------------------
// Host side settings filter
// ----------------------------------------
module host_cfg (
  input  wire logic        i_trace, // Trace mode requested
  input  wire logic [15:0] i_avg,   // Requested average count
  input  wire logic        i_tctl,  // Requested termination control
  output logic      [15:0] o_avg,   // Average count sent to the block
  output logic             o_tctl   // Termination control sent to the block
);
  // A trace run only accepts one count and one control, so the host never offers others.
  assign o_avg  = i_trace ? 16'h0002 : i_avg;
  assign o_tctl = i_trace ? `TCTL_REPEAT : i_tctl;
endmodule

//--- testbench/meas_seq_assertions.sv
`timescale 1ns/1ps
`include "meas_seq_defs.vh"
module meas_seq_chk (
  input wire logic        I_MCLK,                       // Clock
  input wire logic        I_SRST,                       // Reset
  input wire logic        i_start_single,               // Single start
  input wire logic        i_start_cont,                 // Continuous start
  input wire logic        i_abort,                      // Abort
  input wire logic        i_force_trig,                 // Force trigger
  input wire logic [2:0]  i_trig_source,                // Source
  input wire logic [15:0] i_avg_count,                  // Average count
  input wire logic        i_termination_control_select, // Control
  input wire logic [1:0]  o_state,                      // State
  input wire logic        o_chop_inverted,              // Chopper phase
  input wire logic        o_trig_sync,                  // Sync
  input wire logic        o_result_valid,               // Result pulse
  input wire logic        o_result_settled              // Settled flag
);
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (I_SRST);
  property p_rst_idle; $fell(I_SRST) |-> o_state == `ST_IDLE && !o_trig_sync; endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("not idle after reset");
  property p_stay_idle; o_state == `ST_IDLE && !i_start_single && !i_start_cont |=> o_state == `ST_IDLE; endproperty
  a_stay_idle: assert property (p_stay_idle) else $error("left idle without start");
  property p_start; o_state == `ST_IDLE && (i_start_single || i_start_cont) |=> o_state == `ST_WAIT; endproperty
  a_start: assert property (p_start) else $error("start not taken");
  property p_force; o_state == `ST_WAIT && i_force_trig && !i_abort |=> o_state == `ST_MEAS && o_trig_sync; endproperty
  a_force: assert property (p_force) else $error("force trigger not taken");
  property p_hold;
    o_state == `ST_WAIT && i_trig_source == `SRC_HOLD && !i_force_trig && !i_abort |=> o_state == `ST_WAIT;
  endproperty
  a_hold: assert property (p_hold) else $error("hold source left wait");
  property p_chop; $rose(o_trig_sync) |-> !o_chop_inverted ##1 !o_chop_inverted; endproperty
  a_chop: assert property (p_chop) else $error("measurement began inverted");
  property p_settled;
    o_result_valid && (i_avg_count == 16'h0001 || i_termination_control_select == `TCTL_REPEAT) |-> o_result_settled;
  endproperty
  a_settled: assert property (p_settled) else $error("result not settled");
  property p_sync_end; o_result_valid |-> !o_trig_sync; endproperty
  a_sync_end: assert property (p_sync_end) else $error("sync high at result");
endmodule
bind meas_seq meas_seq_chk chk (.I_MCLK(I_MCLK), .I_SRST(I_SRST), .i_start_single(i_start_single),
  .i_start_cont(i_start_cont), .i_abort(i_abort), .i_force_trig(i_force_trig), .i_trig_source(i_trig_source),
  .i_avg_count(i_avg_count), .i_termination_control_select(i_termination_control_select), .o_state(o_state),
  .o_chop_inverted(o_chop_inverted), .o_trig_sync(o_trig_sync), .o_result_valid(o_result_valid),
  .o_result_settled(o_result_settled));

//--- testbench/tb.sv
`timescale 1ns/1ps
`include "meas_seq_defs.vh"
module tb;
  logic mclk, srst, st_s, st_c, abort_p, force_p, bus_p, ext1, ext2, tctl_h, tctl, trace;
  logic [2:0] src;
  logic [23:0] ap;
  logic [15:0] avg_h, avg, tcnt;
  logic [31:0] smp, res;
  logic [1:0] state;
  logic chop, sync, rv, settled, tp;
  logic [23:0] hoff;
  int failures, checked, cyc, nsync, nchop;
  host_cfg host (.i_trace(trace), .i_avg(avg_h), .i_tctl(tctl_h), .o_avg(avg), .o_tctl(tctl));
  meas_seq uut (.I_MCLK(mclk), .I_SRST(srst), .i_start_single(st_s), .i_start_cont(st_c), .i_abort(abort_p),
    .i_force_trig(force_p), .i_bus_trig(bus_p), .i_trig_source(src), .i_trig_slope_neg(1'b0),
    .i_pwr_above_level(1'b0), .i_pwr_above_hyst(1'b0), .i_ext1_trig(ext1), .i_ext2_trig(ext2),
    .i_delay_cycles(24'h000000), .i_dropout_cycles(24'h000000), .i_holdoff_cycles(hoff),
    .i_aperture_cycles(ap), .i_avg_count(avg), .i_trig_count(tcnt), .i_termination_control_select(tctl),
    .i_trace_mode(trace), .i_sample(smp), .o_state(state), .o_chop_inverted(chop), .o_trig_sync(sync),
    .o_result_valid(rv), .o_result(res), .o_result_settled(settled), .o_trace_point(tp));
  initial begin
    mclk = 0;
    forever #12.5 mclk = ~mclk;
  end
  task complete_run;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      complete_run();
    end
  end
  task tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %0t got %0h expected %0h", $time, g, e);
    end
  endtask
  // Commands are one-cycle pulses launched on a rising edge.
  task cmd(input int k);
    @(posedge mclk);
    case (k)
      0: st_s <= 1'b1;
      1: st_c <= 1'b1;
      2: force_p <= 1'b1;
      3: bus_p <= 1'b1;
      default: abort_p <= 1'b1;
    endcase
    @(posedge mclk);
    {st_s, st_c, force_p, bus_p, abort_p} <= 5'h00;
    #1;
  endtask
  task cfg(input logic [2:0] s, input logic [15:0] a, input logic m, input logic [15:0] tc);
    @(posedge mclk);
    src <= s;
    avg_h <= a;
    tctl_h <= m;
    tcnt <= tc;
    tick(1);
  endtask
  // Counts sync and inverted-phase cycles until the next result pulse.
  task run_to_rv;
    int k;
    k = 0;
    nsync = 0;
    nchop = 0;
    while (rv !== 1'b1 && k < 3000) begin
      nsync += (sync === 1'b1);
      nchop += (chop === 1'b1);
      tick(1);
      k++;
    end
  endtask
  task t_repeat;
    cfg(`SRC_HOLD, 16'h0002, `TCTL_REPEAT, 16'h0000);
    cmd(1);
    chk(state, `ST_WAIT);
    cmd(2);
    run_to_rv();
    chk(nsync, 4 * ap);
    chk(nchop, 2 * ap);
    chk(res, smp);
    chk(state, `ST_WAIT);
    cmd(4);
  endtask
  task t_single;
    cfg(`SRC_IMMEDIATE, 16'h0001, `TCTL_MOVING, 16'h0000);
    cmd(0);
    run_to_rv();
    chk(nsync, ap);
    chk(nchop, 0);
    chk(settled, 1);
    tick(3);
    chk(state, `ST_IDLE);
  endtask
  task t_moving;
    logic [31:0] exp_r [3];
    exp_r = '{32'h0000000A, 32'h0000000F, 32'h00000019};
    cfg(`SRC_EXT2, 16'h0002, `TCTL_MOVING, 16'h0003);
    cmd(1);
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk);
      smp <= 32'h0000000A * (i + 1);
      ext2 <= 1'b0;
      tick(5);
      @(posedge mclk);
      ext2 <= 1'b1;
      run_to_rv();
      chk(nsync, 2 * ap);
      chk(res, exp_r[i]);
      chk(settled, i > 0);
    end
    tick(3);
    chk(state, `ST_IDLE);
    ext2 <= 1'b0;
  endtask
  task t_hold_bus;
    cfg(`SRC_HOLD, 16'h0001, `TCTL_REPEAT, 16'h0000);
    cmd(1);
    @(posedge mclk);
    ext1 <= 1'b1;
    cmd(3);
    tick(6);
    chk(state, `ST_WAIT);
    @(posedge mclk);
    src <= `SRC_BUS;
    cmd(3);
    run_to_rv();
    chk(nsync, ap);
    cmd(4);
    chk(state, `ST_IDLE);
  endtask
  // External 1 edges inside the hold-off window must be ignored, later ones taken.
  task t_ext1_holdoff;
    @(posedge mclk);
    ext1 <= 1'b0;
    hoff <= 24'h000020;
    trace <= 1'b1;
    cfg(`SRC_EXT1, 16'h0005, `TCTL_MOVING, 16'h0000);
    cmd(1);
    @(posedge mclk);
    ext1 <= 1'b1;
    run_to_rv();
    chk(nsync, 4 * ap);
    chk(tp, 1);
    @(posedge mclk);
    ext1 <= 1'b0;
    tick(3);
    @(posedge mclk);
    ext1 <= 1'b1;
    tick(6);
    chk(state, `ST_WAIT);
    @(posedge mclk);
    ext1 <= 1'b0;
    tick(10);
    @(posedge mclk);
    ext1 <= 1'b1;
    run_to_rv();
    chk(nsync, 4 * ap);
    cmd(4);
    @(posedge mclk);
    trace <= 1'b0;
    hoff <= 24'h000000;
    tick(1);
  endtask
  initial begin
    {srst, st_s, st_c, abort_p, force_p, bus_p, ext1, ext2, tctl_h, trace} = 10'h200;
    src = `SRC_HOLD;
    ap = 24'h000003;
    avg_h = 16'h0001;
    tcnt = 16'h0000;
    smp = 32'h00000055;
    hoff = 24'h000000;
    tick(8);
    @(posedge mclk);
    srst <= 1'b0;
    tick(4);
    chk(state, `ST_IDLE);
    t_repeat();
    t_single();
    t_moving();
    t_hold_bus();
    t_ext1_holdoff();
    complete_run();
  end
endmodule
